// >>> logic/pmem_pkg.sv
// Contract
// - program store holds 4096 words of 15 bits
// - reset loads program counter with 000H
// - external irq a branches to 004H
// - external irq b branches to 008H
// - timer a overflow branches to 00CH
// - timer b overflow branches to 010H
// - serial transfer request branches to 014H
// - multi-function sources branch to 018H
// - table pointer gives low address byte
// - current page keeps counter_page_bits high nibble
// - last page forces high nibble to ones
// - low fetched byte goes to destination
// - upper bits to table_high_byte, rest zero
// - table_high_byte changes only by table reads
// - table read takes two instruction cycles
// - jump and call carry 11-bit target
// - alu result updates status flags
// - full stack holds request until return
// - twelve-level stack pushed on call, irq
package pmem_pkg;
  // store geometry
  localparam int PROG_WORDS = 4096;
  localparam int WORD_W = 15;
  localparam int ADDR_W = 12;
  localparam int STACK_DEPTH = 12;
  localparam int IRQ_SRCS = 6;
  localparam int MF_SRCS = 4;
  localparam int FLAG_W = 4;
  // entry addresses
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [IRQ_SRCS-1:0][11:0] IRQ_VEC = {
    12'h018, 12'h014, 12'h010, 12'h00c, 12'h008, 12'h004};
  localparam logic [3:0] LAST_PAGE = 4'hf;
  // instruction cycle phases of aclk
  localparam logic [1:0] PH_CAPTURE = 2'h2;
  localparam logic [1:0] PH_LAST = 2'h3;
  // register byte offsets
  localparam logic [7:0] REG_IRQ_EN = 8'h00;
  localparam logic [7:0] REG_IRQ_PEND = 8'h04;
  localparam logic [7:0] REG_TBLP = 8'h08;
  localparam logic [7:0] REG_TABLE_HIGH = 8'h0c;
  localparam logic [7:0] REG_PC = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_PROG_ADDR = 8'h18;
  localparam logic [7:0] REG_PROG_DATA = 8'h1c;
  // field positions
  localparam int EN_LSB = 0;
  localparam int MF_EN_LSB = 8;
  localparam int GIE_BIT = 16;
  localparam int SP_LSB = 16;
  localparam int OVF_BIT = 24;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {MODE_RUN = 1'b0, MODE_TAB = 1'b1} mode_t;
endpackage

// >>> logic/prog_store.sv
`timescale 1ns/100ps
module prog_store
(
  // clock
  input wire logic aclk,
  // load port
  input wire logic wr_en,
  input wire logic [pmem_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [pmem_pkg::WORD_W-1:0] wr_data,
  // read port, one cycle latency
  input wire logic [pmem_pkg::ADDR_W-1:0] rd_addr,
  output logic [pmem_pkg::WORD_W-1:0] rd_data
);
  typedef struct packed {
    logic [pmem_pkg::WORD_W-1:0] rd;
  } store_t;

  logic [pmem_pkg::WORD_W-1:0] mem [pmem_pkg::PROG_WORDS];
  store_t st_r;
  store_t st_nxt;

  always_ff @(posedge aclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_comb
  begin
    st_nxt.rd = mem[rd_addr];
  end

  always_ff @(posedge aclk)
  begin
    st_r <= st_nxt;
  end

  assign rd_data = st_r.rd;
endmodule

// >>> logic/pmem_unit.sv
`timescale 1ns/100ps
module pmem_unit
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // sequencer commands, sampled when cycle_end is high and busy is low, unless an irq is taken
  input wire logic cmd_step,
  input wire logic cmd_jump,
  input wire logic cmd_call,
  input wire logic cmd_ret,
  input wire logic cmd_return_from_irq,
  input wire logic [10:0] cmd_target,
  input wire logic cmd_tab,
  input wire logic cmd_tab_last,
  input wire logic [7:0] cmd_tab_dest,
  // table pointer and alu flags from the core
  input wire logic tblp_we,
  input wire logic [7:0] tblp_wdata,
  input wire logic alu_flags_we,
  input wire logic [pmem_pkg::FLAG_W-1:0] alu_flags,
  // interrupt sources
  input wire logic external_irq_a,
  input wire logic external_irq_b,
  input wire logic tmr_a_ovf,
  input wire logic tmr_b_ovf,
  input wire logic serial_req,
  input wire logic tbase_ovf,
  input wire logic rtc_ovf,
  input wire logic adc_done,
  input wire logic periph_irq,
  // fetch and table results
  output logic [pmem_pkg::ADDR_W-1:0] pc,
  output logic [pmem_pkg::WORD_W-1:0] instr,
  output logic instr_valid,
  output logic cycle_end,
  output logic busy,
  output logic irq_ack,
  output logic tab_wr,
  output logic [7:0] tab_dest,
  output logic [7:0] tab_low,
  output logic [7:0] table_high_byte,
  output logic [pmem_pkg::FLAG_W-1:0] status,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  typedef struct packed {
    logic [1:0] phase;
    pmem_pkg::mode_t mode;
    logic [11:0] pc;
    logic [3:0] sp;
    logic [pmem_pkg::STACK_DEPTH-1:0][11:0] stack;
    logic ovf;
    logic [14:0] instr;
    logic instr_vld;
    logic cyc_end;
    logic busy;
    logic ack;
    logic [11:0] tab_addr;
    logic [7:0] tab_dest;
    logic [7:0] tab_low;
    logic tab_wr;
    logic [7:0] high_byte;
    logic [7:0] tblp;
    logic [pmem_pkg::FLAG_W-1:0] status;
    logic [pmem_pkg::IRQ_SRCS-1:0] en;
    logic [pmem_pkg::MF_SRCS-1:0] mf_en;
    logic gie;
    logic [pmem_pkg::IRQ_SRCS-1:0] pend;
    logic [2:0] pin_prev;
    logic [11:0] prog_addr;
    logic pw_en;
    logic [11:0] pw_addr;
    logic [14:0] pw_data;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } unit_t;

  unit_t st_r;
  unit_t st_nxt;
  logic [14:0] rd_word;
  logic [11:0] rd_addr;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // program store
  // ----------------------------------------
  assign rd_addr = (st_r.mode == pmem_pkg::MODE_TAB) ? st_r.tab_addr : st_r.pc;

  prog_store u_store
  (
    .aclk(aclk),
    .wr_en(st_r.pw_en),
    .wr_addr(st_r.pw_addr),
    .wr_data(st_r.pw_data),
    .rd_addr(rd_addr),
    .rd_data(rd_word)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    logic [pmem_pkg::IRQ_SRCS-1:0] ev;
    logic [pmem_pkg::IRQ_SRCS-1:0] clr;
    logic [pmem_pkg::IRQ_SRCS-1:0] req;
    logic [pmem_pkg::MF_SRCS-1:0] mf_ev;
    logic [2:0] sel;
    logic [31:0] m;
    logic [7:0] ra;
    ev = '0;
    clr = '0;
    req = '0;
    mf_ev = '0;
    sel = '0;
    m = '0;
    ra = '0;
    st_nxt = st_r;
    st_nxt.instr_vld = 1'b0;
    st_nxt.tab_wr = 1'b0;
    st_nxt.ack = 1'b0;
    st_nxt.pw_en = 1'b0;
    st_nxt.phase = st_r.phase + 2'h1;
    st_nxt.cyc_end = (st_nxt.phase == pmem_pkg::PH_LAST);

    // request latching, rising edges on pins
    st_nxt.pin_prev = {periph_irq, external_irq_b, external_irq_a};
    ev[0] = external_irq_a & ~st_r.pin_prev[0];
    ev[1] = external_irq_b & ~st_r.pin_prev[1];
    ev[2] = tmr_a_ovf;
    ev[3] = tmr_b_ovf;
    ev[4] = serial_req;
    mf_ev = {periph_irq & ~st_r.pin_prev[2], adc_done, rtc_ovf, tbase_ovf};
    ev[5] = |(mf_ev & st_r.mf_en);
    req = st_r.pend & st_r.en;
    for (int i = pmem_pkg::IRQ_SRCS - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        sel = 3'(i);
      end
    end

    // capture the word read for this instruction cycle
    if (st_r.phase == pmem_pkg::PH_CAPTURE)
    begin
      if (st_r.mode == pmem_pkg::MODE_TAB)
      begin
        st_nxt.tab_low = rd_word[7:0];
        st_nxt.high_byte = {1'b0, rd_word[14:8]};
        st_nxt.tab_wr = 1'b1;
      end
      else
      begin
        st_nxt.instr = rd_word;
        st_nxt.instr_vld = 1'b1;
      end
    end

    // end of instruction cycle: program counter update
    if (st_r.phase == pmem_pkg::PH_LAST)
    begin
      unique case (st_r.mode)
        pmem_pkg::MODE_TAB:
        begin
          st_nxt.mode = pmem_pkg::MODE_RUN;
          st_nxt.busy = 1'b0;
        end
        pmem_pkg::MODE_RUN:
        begin
          if (st_r.gie && (|req) && (st_r.sp < 4'(pmem_pkg::STACK_DEPTH)))
          begin
            st_nxt.stack[st_r.sp] = st_r.pc;
            st_nxt.sp = st_r.sp + 4'h1;
            st_nxt.pc = pmem_pkg::IRQ_VEC[sel];
            clr[sel] = 1'b1;
            st_nxt.gie = 1'b0;
            st_nxt.ack = 1'b1;
          end
          else if (cmd_ret || cmd_return_from_irq)
          begin
            if (st_r.sp != 4'h0)
            begin
              st_nxt.sp = st_r.sp - 4'h1;
              st_nxt.pc = st_r.stack[st_r.sp - 4'h1];
            end
            if (cmd_return_from_irq)
            begin
              st_nxt.gie = 1'b1;
            end
          end
          else if (cmd_jump || cmd_call)
          begin
            if (cmd_call)
            begin
              if (st_r.sp < 4'(pmem_pkg::STACK_DEPTH))
              begin
                st_nxt.stack[st_r.sp] = st_r.pc + 12'h1;
                st_nxt.sp = st_r.sp + 4'h1;
              end
              else
              begin
                st_nxt.ovf = 1'b1;
              end
            end
            st_nxt.pc = {st_r.pc[11], cmd_target};
          end
          else if (cmd_tab)
          begin
            if (cmd_tab_last)
            begin
              st_nxt.tab_addr = {pmem_pkg::LAST_PAGE, st_r.tblp};
            end
            else
            begin
              st_nxt.tab_addr = {st_r.pc[11:8], st_r.tblp};
            end
            st_nxt.tab_dest = cmd_tab_dest;
            st_nxt.mode = pmem_pkg::MODE_TAB;
            st_nxt.busy = 1'b1;
            st_nxt.pc = st_r.pc + 12'h1;
          end
          else if (cmd_step)
          begin
            st_nxt.pc = st_r.pc + 12'h1;
          end
        end
      endcase
    end

    // alu status flags
    if (alu_flags_we)
    begin
      st_nxt.status = alu_flags;
    end

    // ----------------------------------------
    // axi4-lite write channel
    // ----------------------------------------
    if (awvalid && st_r.awready)
    begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = {awaddr[7:2], 2'h0};
    end
    if (wvalid && st_r.wready)
    begin
      st_nxt.w_have = 1'b1;
      st_nxt.w_data = wdata;
      st_nxt.w_strb = wstrb;
    end
    if (st_r.aw_have && st_r.w_have && !st_r.bvalid)
    begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = pmem_pkg::RESP_OKAY;
      case (st_r.aw_addr)
        pmem_pkg::REG_IRQ_EN:
        begin
          m = merge({15'h0, st_r.gie, 4'h0, st_r.mf_en, 2'h0, st_r.en},
                    st_r.w_data, st_r.w_strb);
          st_nxt.en = m[pmem_pkg::EN_LSB +: pmem_pkg::IRQ_SRCS];
          st_nxt.mf_en = m[pmem_pkg::MF_EN_LSB +: pmem_pkg::MF_SRCS];
          st_nxt.gie = m[pmem_pkg::GIE_BIT];
        end
        pmem_pkg::REG_IRQ_PEND:
        begin
          m = merge(32'h0000_0000, st_r.w_data, st_r.w_strb);
          clr = clr | m[pmem_pkg::IRQ_SRCS-1:0];
        end
        pmem_pkg::REG_TBLP:
        begin
          m = merge({24'h0, st_r.tblp}, st_r.w_data, st_r.w_strb);
          st_nxt.tblp = m[7:0];
        end
        pmem_pkg::REG_PROG_ADDR:
        begin
          m = merge({20'h0, st_r.prog_addr}, st_r.w_data, st_r.w_strb);
          st_nxt.prog_addr = m[11:0];
        end
        pmem_pkg::REG_PROG_DATA:
        begin
          m = merge(32'h0000_0000, st_r.w_data, st_r.w_strb);
          st_nxt.pw_en = 1'b1;
          st_nxt.pw_addr = st_r.prog_addr;
          st_nxt.pw_data = m[14:0];
          st_nxt.prog_addr = st_r.prog_addr + 12'h1;
        end
        default:
        begin
          // read-only or unmapped
          st_nxt.bresp = pmem_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_r.bvalid && bready)
    begin
      st_nxt.bvalid = 1'b0;
    end
    st_nxt.awready = !st_nxt.aw_have;
    st_nxt.wready = !st_nxt.w_have;

    // core write of the table pointer takes priority over the bus
    if (tblp_we)
    begin
      st_nxt.tblp = tblp_wdata;
    end

    // a new event wins over any clear in the same cycle
    st_nxt.pend = (st_r.pend & ~clr) | ev;

    // ----------------------------------------
    // axi4-lite read channel
    // ----------------------------------------
    if (st_r.rvalid && rready)
    begin
      st_nxt.rvalid = 1'b0;
      st_nxt.arready = 1'b1;
    end
    if (arvalid && st_r.arready)
    begin
      ra = {araddr[7:2], 2'h0};
      st_nxt.arready = 1'b0;
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = pmem_pkg::RESP_OKAY;
      st_nxt.rdata = 32'h0000_0000;
      case (ra)
        pmem_pkg::REG_IRQ_EN:
        begin
          st_nxt.rdata[pmem_pkg::EN_LSB +: pmem_pkg::IRQ_SRCS] = st_r.en;
          st_nxt.rdata[pmem_pkg::MF_EN_LSB +: pmem_pkg::MF_SRCS] = st_r.mf_en;
          st_nxt.rdata[pmem_pkg::GIE_BIT] = st_r.gie;
        end
        pmem_pkg::REG_IRQ_PEND:
        begin
          st_nxt.rdata[pmem_pkg::IRQ_SRCS-1:0] = st_r.pend;
        end
        pmem_pkg::REG_TBLP:
        begin
          st_nxt.rdata[7:0] = st_r.tblp;
        end
        pmem_pkg::REG_TABLE_HIGH:
        begin
          st_nxt.rdata[7:0] = st_r.high_byte;
        end
        pmem_pkg::REG_PC:
        begin
          st_nxt.rdata[11:0] = st_r.pc;
          st_nxt.rdata[pmem_pkg::SP_LSB +: 4] = st_r.sp;
          st_nxt.rdata[pmem_pkg::OVF_BIT] = st_r.ovf;
        end
        pmem_pkg::REG_STATUS:
        begin
          st_nxt.rdata[pmem_pkg::FLAG_W-1:0] = st_r.status;
        end
        pmem_pkg::REG_PROG_ADDR:
        begin
          st_nxt.rdata[11:0] = st_r.prog_addr;
        end
        pmem_pkg::REG_PROG_DATA:
        begin
          st_nxt.rdata = 32'h0000_0000;
        end
        default:
        begin
          st_nxt.rresp = pmem_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= '0;
      st_r.pc <= pmem_pkg::PC_RESET;
      st_r.mode <= pmem_pkg::MODE_RUN;
      st_r.awready <= 1'b1;
      st_r.wready <= 1'b1;
      st_r.arready <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign pc = st_r.pc;
  assign instr = st_r.instr;
  assign instr_valid = st_r.instr_vld;
  assign cycle_end = st_r.cyc_end;
  assign busy = st_r.busy;
  assign irq_ack = st_r.ack;
  assign tab_wr = st_r.tab_wr;
  assign tab_dest = st_r.tab_dest;
  assign tab_low = st_r.tab_low;
  assign table_high_byte = st_r.high_byte;
  assign status = st_r.status;
  assign awready = st_r.awready;
  assign wready = st_r.wready;
  assign bresp = st_r.bresp;
  assign bvalid = st_r.bvalid;
  assign arready = st_r.arready;
  assign rdata = st_r.rdata;
  assign rresp = st_r.rresp;
  assign rvalid = st_r.rvalid;
endmodule

// >>> verification/pmem_checker.sv
`timescale 1ns/100ps
module pmem_checker
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // sequencer side
  input wire logic cmd_jump,
  input wire logic cmd_call,
  input wire logic cmd_ret,
  input wire logic cmd_return_from_irq,
  input wire logic [10:0] cmd_target,
  input wire logic alu_flags_we,
  input wire logic [pmem_pkg::FLAG_W-1:0] alu_flags,
  // results
  input wire logic [pmem_pkg::ADDR_W-1:0] pc,
  input wire logic cycle_end,
  input wire logic busy,
  input wire logic irq_ack,
  input wire logic tab_wr,
  input wire logic [7:0] table_high_byte,
  input wire logic [pmem_pkg::FLAG_W-1:0] status
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_reset_pc: assert property (
    $rose(aresetn) |-> pc == 12'h000
  ) else $error("pc not at reset entry");
  a_ack_vector: assert property (
    irq_ack |-> pc inside {12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018}
  ) else $error("irq taken to wrong entry");
  a_tab_length: assert property (
    $rose(busy) |-> busy[*4] ##1 !busy
  ) else $error("table read length wrong");
  a_tab_write: assert property (
    tab_wr |-> busy
  ) else $error("table write outside table read");
  a_high_hold: assert property (
    $changed(table_high_byte) |-> tab_wr
  ) else $error("high byte changed without table read");
  a_high_msb: assert property (
    tab_wr |-> table_high_byte[7] == 1'b0
  ) else $error("unused high bit set");
  a_jump_target: assert property (
    cycle_end && !busy && (cmd_jump || cmd_call) && !cmd_ret && !cmd_return_from_irq
    |=> irq_ack || pc[10:0] == $past(cmd_target)
  ) else $error("branch target not loaded");
  a_status_load: assert property (
    alu_flags_we |=> status == $past(alu_flags)
  ) else $error("status not updated");
endmodule

bind pmem_unit pmem_checker pmem_checker_i (.aclk, .aresetn, .cmd_jump, .cmd_call, .cmd_ret,
  .cmd_return_from_irq, .cmd_target, .alu_flags_we, .alu_flags, .pc, .cycle_end, .busy,
  .irq_ack, .tab_wr, .table_high_byte, .status);

// >>> verification/seq_model.sv
`timescale 1ns/100ps
module seq_model
(
  // clock and design status
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cycle_end,
  input wire logic busy,
  // requests from the bench
  input wire logic go,
  input wire logic [2:0] op,
  input wire logic [8:0] fire,
  // commands and source events
  output logic [6:0] cmd,
  output logic [8:0] src,
  output logic done
);
  logic act;

  initial
  begin
    cmd = 7'h00;
    src = 9'h000;
    done = 1'b0;
    act = 1'b0;
  end

  // one command per instruction cycle, held until taken at a free cycle end
  always @(posedge aclk)
  begin
    src <= fire;
    done <= 1'b0;
    if (!aresetn)
    begin
      cmd <= 7'h00;
      act <= 1'b0;
    end
    else if (go && !act)
    begin
      cmd <= 7'h01 << op;
      act <= 1'b1;
    end
    else if (act && cycle_end && !busy)
    begin
      cmd <= 7'h00;
      act <= 1'b0;
      done <= 1'b1;
    end
  end
endmodule

// >>> verification/program_memory_vector_table_read_test.sv
`timescale 1ns/100ps
module program_memory_vector_table_read_test;
  localparam logic [1:0] okay = pmem_pkg::RESP_OKAY;
  localparam logic [1:0] err = pmem_pkg::RESP_SLVERR;
  logic aclk, aresetn, go, done, tblp_we, alu_flags_we, busy, cycle_end, irq_ack, tab_wr;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic instr_valid;
  logic [14:0] instr;
  logic [2:0] op;
  logic [6:0] cmd;
  logic [8:0] fire, src;
  logic [10:0] cmd_target;
  logic [7:0] dest_sel, tblp_wdata, awaddr, araddr, tab_dest, tab_low, table_high_byte;
  logic [3:0] alu_flags, status;
  logic [11:0] pc;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int failures, checks;

  pmem_unit pmem_unit_i (.aclk, .aresetn, .cmd_step(cmd[0]), .cmd_jump(cmd[1]),
    .cmd_call(cmd[2]), .cmd_ret(cmd[3]), .cmd_return_from_irq(cmd[4]), .cmd_target,
    .cmd_tab(cmd[5] | cmd[6]), .cmd_tab_last(cmd[6]), .cmd_tab_dest(dest_sel), .tblp_we,
    .tblp_wdata, .alu_flags_we, .alu_flags, .external_irq_a(src[0]), .external_irq_b(src[1]),
    .tmr_a_ovf(src[2]), .tmr_b_ovf(src[3]), .serial_req(src[4]), .tbase_ovf(src[5]),
    .rtc_ovf(src[6]), .adc_done(src[7]), .periph_irq(src[8]), .pc, .instr, .instr_valid,
    .cycle_end, .busy, .irq_ack, .tab_wr, .tab_dest, .tab_low, .table_high_byte, .status,
    .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

  seq_model seq_model_i (.aclk, .aresetn, .cycle_end, .busy, .go, .op, .fire, .cmd, .src,
    .done);

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic conclude;
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic tmo(input logic ok);
    if (ok !== 1'b1)
    begin
      failures++;
      conclude();
    end
  endtask

  // ----------------------------------------
  // bus, command and event drivers
  // ----------------------------------------
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 30 && (n == 0 || bvalid !== 1'b1); n++)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    tmo(bvalid);
    bready <= 1'b0;
    chk("bresp", 32'(bresp), 32'(r));
    @(posedge aclk);
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 30 && (n == 0 || rvalid !== 1'b1); n++)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    tmo(rvalid);
    rready <= 1'b0;
    chk("rdata", rdata, d);
    chk("rresp", 32'(rresp), 32'(r));
    @(posedge aclk);
  endtask

  task automatic run(input logic [2:0] o);
    int n;
    op <= o;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    @(posedge aclk);
    for (n = 0; n < 20 && done !== 1'b1; n++) @(posedge aclk);
    tmo(done);
  endtask

  task automatic pulse(input logic [8:0] m);
    fire <= m;
    @(posedge aclk);
    fire <= 9'h000;
  endtask

  task automatic ack(input logic [11:0] v);
    int n;
    for (n = 0; n < 40 && irq_ack !== 1'b1; n++) @(posedge aclk);
    tmo(irq_ack);
    chk("vector", 32'(pc), 32'(v));
  endtask

  task automatic load(input logic [11:0] a, input logic [14:0] w);
    axw(8'h18, 32'(a), okay);
    axw(8'h1c, 32'(w), okay);
  endtask

  task automatic tab(input logic [7:0] p, input logic l, input logic [14:0] w);
    int n;
    tblp_wdata <= p;
    tblp_we <= 1'b1;
    dest_sel <= p ^ 8'h5a;
    @(posedge aclk);
    tblp_we <= 1'b0;
    run(l ? 3'h6 : 3'h5);
    for (n = 0; n < 20 && busy !== 1'b0; n++) @(posedge aclk);
    tmo(!busy);
    chk("low", 32'(tab_low), 32'(w[7:0]));
    chk("high", 32'(table_high_byte), 32'({1'b0, w[14:8]}));
    chk("dest", 32'(tab_dest), 32'(p ^ 8'h5a));
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    @(posedge aclk);
    chk("pc", 32'(pc), 32'h0000_0000);
    axr(8'h10, 32'h0000_0000, okay);
    axr(8'h20, 32'h0000_0000, err);
  endtask

  task automatic t_table;
    int n;
    load(12'h324, 15'h1234);
    load(12'h305, 15'h6b9e);
    load(12'h005, 15'h1111);
    load(12'hf05, 15'h2222);
    load(12'hfff, 15'h7fff);
    cmd_target <= 11'h321;
    run(3'h1);
    chk("jump", 32'(pc), 32'h0000_0321);
    tab(8'h05, 1'b0, 15'h6b9e);
    tab(8'hff, 1'b1, 15'h7fff);
    run(3'h0);
    chk("step", 32'(pc), 32'h0000_0324);
    for (n = 0; n < 8 && instr_valid !== 1'b1; n++) @(posedge aclk);
    chk("fetch valid", 32'(instr_valid), 32'h0000_0001);
    chk("fetch", 32'(instr), 32'h0000_1234);
  endtask

  task automatic t_status;
    alu_flags <= 4'ha;
    alu_flags_we <= 1'b1;
    @(posedge aclk);
    alu_flags_we <= 1'b0;
    @(posedge aclk);
    chk("status", 32'(status), 32'h0000_000a);
    axr(8'h14, 32'h0000_000a, okay);
    axw(8'h0c, 32'h0000_0000, err);
    chk("high", 32'(table_high_byte), 32'h0000_007f);
  endtask

  task automatic t_irqs;
    int i;
    logic [11:0] p;
    axw(8'h00, 32'h0001_0f3f, okay);
    for (i = 0; i < 9; i++)
    begin
      p = pc;
      pulse(9'h001 << i);
      ack((i < 5) ? 12'(4 * i + 4) : 12'h018);
      run(3'h4);
      chk("return", 32'(pc), 32'(p));
    end
    pulse(9'h01a);
    ack(12'h008);
    run(3'h4);
    ack(12'h010);
    run(3'h4);
    ack(12'h014);
    run(3'h4);
  endtask

  task automatic t_mask;
    axw(8'h00, 32'h0001_0f3e, okay);
    pulse(9'h001);
    repeat (8) @(posedge aclk);
    axr(8'h04, 32'h0000_0001, okay);
    axw(8'h04, 32'h0000_0001, okay);
    axr(8'h04, 32'h0000_0000, okay);
  endtask

  task automatic t_stack;
    int i;
    axw(8'h00, 32'h0001_0f3f, okay);
    for (i = 0; i < 12; i++) run(3'h2);
    axr(8'h10, 32'h000c_0321, okay);
    pulse(9'h001);
    repeat (8) @(posedge aclk);
    axr(8'h04, 32'h0000_0001, okay);
    run(3'h3);
    ack(12'h004);
  endtask

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  initial
  begin
    failures = 0;
    checks = 0;
    aresetn = 1'b0;
    {go, tblp_we, alu_flags_we, awvalid, wvalid, bready, arvalid, rready} = '0;
    {op, fire, cmd_target, dest_sel, tblp_wdata, alu_flags, awaddr, wdata, araddr} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_table();
    t_status();
    t_irqs();
    t_mask();
    t_stack();
    conclude();
  end
endmodule
